// [inc/sdpc_map.svh]
/*
  Constants for the SDRAM pin command interface: field positions, widths, latencies.
  Assumes inclusion by its bare name from the package and design files.
*/
`ifndef SDPC_MAP_SVH
`define SDPC_MAP_SVH
`define SDPC_ADDR_W       12
`define SDPC_DQ_W         16
`define SDPC_BANKS        4
`define SDPC_PRE_ALL_BIT  10
`define SDPC_COL_W_X16    9
`define SDPC_COL_W_X8     10
`define SDPC_COL_W_X4     11
`define SDPC_COL11_BIT    11
`define SDPC_MASK_LAT     2
`define SDPC_BURST_W      9
`define SDPC_BURST_LEN    9'h004
`define SDPC_ORG_X4       2'h0
`define SDPC_ORG_X8       2'h1
`define SDPC_ORG_X16      2'h2
`endif

// [inc/sdpc_pkg.sv]
/*
  Types for the SDRAM pin command interface.
  Assumes sdpc_map.svh is on the include path.
*/
`include "sdpc_map.svh"
package sdpc_pkg;
  // decoded command on cs/ras/cas/we
  typedef enum logic [3:0] {
    SDPC_CMD_INHIBIT, SDPC_CMD_NOP, SDPC_CMD_ACTIVE, SDPC_CMD_READ, SDPC_CMD_WRITE,
    SDPC_CMD_BURST_TERM, SDPC_CMD_PRECHARGE, SDPC_CMD_REFRESH, SDPC_CMD_MODE_LOAD
  } sdpc_cmd_t;
  // clock-gate state of the core
  typedef enum logic [1:0] {SDPC_ST_RUN, SDPC_ST_SUSPEND, SDPC_ST_PDOWN, SDPC_ST_SELF_REF} sdpc_pwr_t;
endpackage : sdpc_pkg

// [src/sdpc_cmd_if.sv]
/*
  Pin-level command front end of a quad-bank SDRAM: command decode, clock gating,
  bank/row/column capture, precharge decode, byte masking and read output disable.
  Assumes the controller drives every pin synchronously to ref_clk.
*/
// Operation
// [R01] every input is sampled on the rising edge, which also steps the burst counter and output registers.
// [R02] clock gate low stops internal clocking, giving power-down, self refresh or clock suspend.
// [R03] clock gate is synchronous except between power-down or self refresh entry and exit.
// [R04] input buffers are disabled during power-down and self refresh.
// [R05] chip select high masks commands while running bursts and masking continue.
// [R06] the controller encodes commands on chip select, row, column and write strobes.
// [R07] write data of a cycle with its mask high is discarded.
// [R08] a mask high during a read floats the data outputs two clocks later.
// [R09] x16 uses low mask for bits 0-7 and high mask for 8-15; narrower parts use only the high mask.
// [R10] the two bank select inputs name the bank of activate, read, write and precharge.
// [R11] activate captures the full twelve-bit row address.
// [R12] read and write take the column from the address bits that suit the organization.
// [R13] address bit 10 with read or write selects auto precharge.
// [R14] precharge with bit 10 high closes all banks, low only the selected bank.
// [R15] mode load carries its op-code on the address inputs.
// [R16] the controller drives nop or deselect in every idle cycle.
`timescale 1ns/1ps
`include "sdpc_map.svh"
module sdpc_cmd_if (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  // organization strap: 0 x4, 1 x8, 2 x16
  input  wire logic [1:0]                   org_sel,
  // command pins
  input  wire logic                         clk_gate,
  input  wire logic                         cs_n,
  input  wire logic                         ras_n,
  input  wire logic                         cas_n,
  input  wire logic                         we_n,
  input  wire logic                         bank_sel_0,
  input  wire logic                         bank_sel_1,
  input  wire logic [`SDPC_ADDR_W-1:0]      addr,
  input  wire logic                         low_byte_mask,
  input  wire logic                         high_byte_mask,
  // data pins
  input  wire logic [`SDPC_DQ_W-1:0]        dq_in,
  output logic      [`SDPC_DQ_W-1:0]        dq_out,
  output logic      [`SDPC_DQ_W-1:0]        dq_oe,
  // read data from the array
  input  wire logic [`SDPC_DQ_W-1:0]        rd_data,
  // decoded core side
  output sdpc_pkg::sdpc_cmd_t               cmd_out,
  output logic                              cmd_valid,
  output logic      [1:0]                   cmd_bank,
  output logic      [`SDPC_ADDR_W-1:0]      row_addr,
  output logic      [`SDPC_COL_W_X4-1:0]    col_addr,
  output logic                              auto_pre,
  output logic      [`SDPC_BANKS-1:0]       pre_banks,
  output logic      [`SDPC_ADDR_W-1:0]      mode_opcode,
  output logic                              mode_load,
  output logic      [`SDPC_DQ_W-1:0]        wr_data,
  output logic      [`SDPC_DQ_W-1:0]        wr_byte_en,
  output logic                              wr_valid,
  output logic                              rd_active,
  output logic                              core_clk_en,
  output logic                              in_buf_en,
  output sdpc_pkg::sdpc_pwr_t               pwr_state
);
  import sdpc_pkg::*;

  // command truth table, shared by decode and assertions
  function automatic sdpc_cmd_t sdpc_decode(input logic c, input logic r, input logic a, input logic w);
    sdpc_cmd_t d;
    d = SDPC_CMD_NOP;
    if (c) begin
      d = SDPC_CMD_INHIBIT;
    end else begin
      case ({r, a, w})
        3'h7: d = SDPC_CMD_NOP;
        3'h3: d = SDPC_CMD_ACTIVE;
        3'h5: d = SDPC_CMD_READ;
        3'h4: d = SDPC_CMD_WRITE;
        3'h6: d = SDPC_CMD_BURST_TERM;
        3'h2: d = SDPC_CMD_PRECHARGE;
        3'h1: d = SDPC_CMD_REFRESH;
        3'h0: d = SDPC_CMD_MODE_LOAD;
        default: d = SDPC_CMD_NOP;
      endcase
    end
    return d;
  endfunction

  // state
  sdpc_pwr_t                   pwr_r, pwr_nxt;
  logic [`SDPC_BANKS-1:0]      open_r, open_nxt;
  logic [`SDPC_BURST_W-1:0]    burst_cnt_r, burst_cnt_nxt;
  logic                        rd_burst_r, wr_burst_r;
  logic [1:0]                  rmask_d1_r, rmask_d2_r;
  logic                        gate_prev_r;

  // decode of pins sampled this edge
  wire sdpc_cmd_t  cmd_w     = sdpc_decode(cs_n, ras_n, cas_n, we_n); // [R05] [R06]
  wire             awake_w   = (pwr_r == SDPC_ST_RUN);
  wire             clk_on_w  = awake_w && gate_prev_r && clk_gate;    // [R02]
  wire [1:0]       bank_w    = {bank_sel_1, bank_sel_0};              // [R10]
  wire             idle_w    = (open_r == '0);
  wire             burst_w   = rd_burst_r || wr_burst_r;
  wire             is_rd_w   = clk_on_w && (cmd_w == SDPC_CMD_READ);
  wire             is_wr_w   = clk_on_w && (cmd_w == SDPC_CMD_WRITE);
  wire             is_pre_w  = clk_on_w && (cmd_w == SDPC_CMD_PRECHARGE);
  wire             is_act_w  = clk_on_w && (cmd_w == SDPC_CMD_ACTIVE);
  wire             is_term_w = clk_on_w && (cmd_w == SDPC_CMD_BURST_TERM);
  wire             pre_all_w = addr[`SDPC_PRE_ALL_BIT];                // [R13] [R14]
  wire [`SDPC_BANKS-1:0] bank_hot_w = 4'h1 << bank_w;
  wire [`SDPC_BANKS-1:0] pre_w = pre_all_w ? 4'hF : bank_hot_w;        // [R14]
  // narrower parts keep only the high mask pin
  wire             x16_w     = (org_sel == `SDPC_ORG_X16);
  wire [1:0]       mask_w    = x16_w ? {high_byte_mask, low_byte_mask}
                                     : {high_byte_mask, high_byte_mask}; // [R09]
  wire [`SDPC_DQ_W-1:0] byte_en_w = {{8{~mask_w[1]}}, {8{~mask_w[0]}}}; // [R07] [R09]
  // column width per organization
  wire [`SDPC_COL_W_X4-1:0] col_w =
    (org_sel == `SDPC_ORG_X4) ? {addr[`SDPC_COL11_BIT], addr[`SDPC_COL_W_X8-1:0]} :
    (org_sel == `SDPC_ORG_X8) ? {1'b0, addr[`SDPC_COL_W_X8-1:0]} :
                                {2'h0, addr[`SDPC_COL_W_X16-1:0]};     // [R12]

  // clock-gate state machine; power-down exit is taken on the gate level alone
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      SDPC_ST_RUN, SDPC_ST_SUSPEND: begin
        if (!clk_gate && burst_w) begin
          pwr_nxt = SDPC_ST_SUSPEND;                                   // [R02]
        end else if (!clk_gate && idle_w && !cs_n && cmd_w == SDPC_CMD_REFRESH) begin
          pwr_nxt = SDPC_ST_SELF_REF;                                  // [R02]
        end else if (!clk_gate) begin
          pwr_nxt = SDPC_ST_PDOWN;                                     // [R02]
        end else begin
          pwr_nxt = SDPC_ST_RUN;
        end
      end
      SDPC_ST_PDOWN, SDPC_ST_SELF_REF: begin
        if (clk_gate) begin
          pwr_nxt = SDPC_ST_RUN;                                       // [R03]
        end
      end
      default: pwr_nxt = SDPC_ST_RUN;
    endcase
  end

  // bank open tracking
  always_comb begin
    open_nxt = open_r;
    if (is_act_w) begin
      open_nxt = open_r | bank_hot_w;
    end else if (is_pre_w) begin
      open_nxt = open_r & ~pre_w;
    end else if ((is_rd_w || is_wr_w) && pre_all_w) begin
      open_nxt = open_r & ~bank_hot_w;                                 // [R13]
    end
  end

  // burst counter steps only on live clocks; chip select high does not stop it
  always_comb begin
    burst_cnt_nxt = burst_cnt_r;
    if (is_rd_w || is_wr_w) begin
      burst_cnt_nxt = `SDPC_BURST_LEN - 9'h001;
    end else if (is_term_w) begin
      burst_cnt_nxt = '0;
    end else if (clk_on_w && burst_cnt_r != '0) begin
      burst_cnt_nxt = burst_cnt_r - 9'h001;                            // [R01] [R05]
    end
  end

  // state registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pwr_r       <= SDPC_ST_RUN;
      open_r      <= '0;
      burst_cnt_r <= '0;
      rd_burst_r  <= 1'b0;
      wr_burst_r  <= 1'b0;
      gate_prev_r <= 1'b1;
    end else begin
      pwr_r       <= pwr_nxt;
      open_r      <= open_nxt;
      burst_cnt_r <= burst_cnt_nxt;
      gate_prev_r <= clk_gate;                                         // [R02]
      rd_burst_r  <= is_rd_w || (rd_burst_r && !is_wr_w && !is_term_w && burst_cnt_nxt != '0);
      wr_burst_r  <= is_wr_w || (wr_burst_r && !is_rd_w && !is_term_w && burst_cnt_nxt != '0);
    end
  end

  // read mask pipeline: two clocks from sample to high impedance
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rmask_d1_r <= 2'h3;
      rmask_d2_r <= 2'h3;
    end else if (clk_on_w) begin
      rmask_d1_r <= mask_w;                                            // [R08]
      rmask_d2_r <= rmask_d1_r;                                        // [R08]
    end
  end

  // output registers; buffers forced off in power-down and self refresh
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_out     <= SDPC_CMD_NOP;
      cmd_valid   <= 1'b0;
      cmd_bank    <= '0;
      row_addr    <= '0;
      col_addr    <= '0;
      auto_pre    <= 1'b0;
      pre_banks   <= '0;
      mode_opcode <= '0;
      mode_load   <= 1'b0;
      wr_data     <= '0;
      wr_byte_en  <= '0;
      wr_valid    <= 1'b0;
      rd_active   <= 1'b0;
      dq_out      <= '0;
      dq_oe       <= '0;
      core_clk_en <= 1'b1;
      in_buf_en   <= 1'b1;
      pwr_state   <= SDPC_ST_RUN;
    end else begin
      cmd_out     <= clk_on_w ? cmd_w : SDPC_CMD_NOP;                  // [R01]
      cmd_valid   <= clk_on_w && !cs_n && cmd_w != SDPC_CMD_NOP;       // [R05]
      cmd_bank    <= (is_act_w || is_rd_w || is_wr_w || is_pre_w) ? bank_w : cmd_bank; // [R10]
      row_addr    <= is_act_w ? addr : row_addr;                       // [R11]
      col_addr    <= (is_rd_w || is_wr_w) ? col_w : col_addr;          // [R12]
      auto_pre    <= (is_rd_w || is_wr_w) ? pre_all_w : auto_pre;      // [R13]
      pre_banks   <= is_pre_w ? pre_w : '0;                            // [R14]
      mode_load   <= clk_on_w && cmd_w == SDPC_CMD_MODE_LOAD;
      mode_opcode <= (clk_on_w && cmd_w == SDPC_CMD_MODE_LOAD) ? addr : mode_opcode; // [R15]
      wr_valid    <= clk_on_w && (is_wr_w || wr_burst_r);
      wr_data     <= dq_in;
      wr_byte_en  <= byte_en_w;                                        // [R07]
      rd_active   <= clk_on_w ? rd_burst_r : rd_active;
      dq_out      <= clk_on_w ? rd_data : dq_out;                      // [R01]
      dq_oe       <= (rd_burst_r && clk_on_w) ? {{8{~rmask_d2_r[1]}}, {8{~rmask_d2_r[0]}}}
                   : (rd_burst_r ? dq_oe : '0);                        // [R08]
      core_clk_en <= clk_on_w;                                         // [R02]
      in_buf_en   <= (pwr_nxt != SDPC_ST_PDOWN) && (pwr_nxt != SDPC_ST_SELF_REF); // [R04]
      pwr_state   <= pwr_nxt;
    end
  end

  // checks
  AST_MASK_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_burst_r && clk_on_w && mask_w == 2'h3) |=> (wr_byte_en == '0)) // [R07]
    else $error("masked write byte not discarded");
  AST_READ_FLOAT: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_on_w && mask_w == 2'h3) ##1 clk_on_w ##1 (clk_on_w && rd_burst_r) |=> (dq_oe == '0)) // [R08]
    else $error("read output not floated two clocks after mask");
  AST_CS_MASK: assert property (@(posedge ref_clk) disable iff (rst)
    cs_n |=> !cmd_valid && !mode_load && pre_banks == '0)              // [R05]
    else $error("command taken with chip select high");
  AST_PRE_ALL: assert property (@(posedge ref_clk) disable iff (rst)
    (is_pre_w && pre_all_w) |=> (pre_banks == 4'hF) && (open_r == '0)) // [R14]
    else $error("precharge all missed a bank");
  AST_ROW_CAP: assert property (@(posedge ref_clk) disable iff (rst)
    is_act_w |=> (row_addr == $past(addr)) && (cmd_bank == $past(bank_w))) // [R11]
    else $error("row or bank not captured");
  AST_X8_COL: assert property (@(posedge ref_clk) disable iff (rst)
    (is_rd_w && org_sel == `SDPC_ORG_X8) |=> col_addr[`SDPC_COL_W_X4-1] == 1'b0) // [R12]
    else $error("x8 column carries bit 11");
  AST_SLEEP_BUF: assert property (@(posedge ref_clk) disable iff (rst)
    (pwr_r == SDPC_ST_PDOWN && !clk_gate) |-> !in_buf_en && !core_clk_en) // [R04]
    else $error("buffers live in power-down");
  AST_SUSPEND_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    (burst_w && !clk_gate) |=> $stable(burst_cnt_r))                   // [R02]
    else $error("burst counter moved in clock suspend");
  AST_NARROW_MASK: assert property (@(posedge ref_clk) disable iff (rst)
    (!x16_w && low_byte_mask && !high_byte_mask) |=> wr_byte_en == 16'hFFFF) // [R09]
    else $error("low mask used on narrow part");
endmodule // sdpc_cmd_if

// [dv/sdpc_ctl_model.sv]
/*
  Behavioural memory controller driving the SDRAM command and data pins.
  Assumes one clock; pins change 1 ns after a rising edge of ref_clk.
*/
`timescale 1ns/1ps
module sdpc_ctl_model (
  // clock
  input  wire logic        ref_clk,
  // command pins
  output logic             clk_gate,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic             bank_sel_0,
  output logic             bank_sel_1,
  output logic [11:0]      addr,
  // masks and write data
  output logic             low_byte_mask,
  output logic             high_byte_mask,
  output logic [15:0]      dq_in
);
  // deselected and idle from time zero
  initial begin
    {clk_gate, cs_n, ras_n, cas_n, we_n} = 5'h1F;
    {bank_sel_1, bank_sel_0, addr, low_byte_mask, high_byte_mask, dq_in} = '0;
  end
  // one command, taken at the next edge; cs high gives deselect
  task automatic issue(input logic cs, input logic [2:0] rcw, input logic [1:0] bk, input logic [11:0] a);
    @(posedge ref_clk);
    #1;
    cs_n = cs;
    {ras_n, cas_n, we_n} = rcw;
    {bank_sel_1, bank_sel_0} = bk;
    addr = a;
  endtask
  // nop; address and data flip so stale values never look valid
  task automatic idle();
    @(posedge ref_clk);
    #1;
    {ras_n, cas_n, we_n} = 3'h7;
    {low_byte_mask, high_byte_mask} = 2'h0;
    addr = ~addr;
    dq_in = ~dq_in;
  endtask
  // masks {high, low} and data for the current cycle
  task automatic data(input logic [1:0] m, input logic [15:0] d);
    {high_byte_mask, low_byte_mask} = m;
    dq_in = d;
  endtask
  task automatic gate(input logic g);
    clk_gate = g;
  endtask
endmodule // sdpc_ctl_model

// [dv/sdram_pin_command_interface_test.sv]
/*
  Self-checking bench for sdpc_cmd_if, one task per scenario.
  Assumes sdpc_ctl_model drives the pins; array read data is a bench-held word, 16'hC3A5 until t_rmask sets 16'h5A0F.
*/
`timescale 1ns/1ps
`include "sdpc_map.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module sdram_pin_command_interface_test;
  import sdpc_pkg::*;
  localparam logic [2:0] C_MODE = 3'h0, C_REF = 3'h1, C_PRE = 3'h2, C_ACT = 3'h3, C_WR = 3'h4, C_RD = 3'h5;
  localparam logic [2:0] C_TERM = 3'h6;
  logic ref_clk = 1'b0, rst = 1'b1;
  logic [1:0] org_sel = `SDPC_ORG_X16;
  logic clk_gate, cs_n, ras_n, cas_n, we_n, bank_sel_0, bank_sel_1, low_byte_mask, high_byte_mask;
  logic [11:0] addr, row_addr, mode_opcode;
  logic [15:0] dq_in, dq_out, dq_oe, wr_data, wr_byte_en, rd_data = 16'hC3A5;
  logic [10:0] col_addr;
  logic [3:0] pre_banks;
  logic [1:0] cmd_bank;
  logic cmd_valid, auto_pre, mode_load, wr_valid, rd_active, core_clk_en, in_buf_en;
  sdpc_cmd_t cmd_out;
  sdpc_pwr_t pwr_state;
  int fail_count = 0, checks = 0;
  // 100 MHz
  always #5 ref_clk = ~ref_clk;
  sdpc_cmd_if dut_u (.ref_clk, .rst, .org_sel, .clk_gate, .cs_n, .ras_n, .cas_n, .we_n, .bank_sel_0,
    .bank_sel_1, .addr, .low_byte_mask, .high_byte_mask, .dq_in, .dq_out, .dq_oe, .rd_data, .cmd_out,
    .cmd_valid, .cmd_bank, .row_addr, .col_addr, .auto_pre, .pre_banks, .mode_opcode, .mode_load,
    .wr_data, .wr_byte_en, .wr_valid, .rd_active, .core_clk_en, .in_buf_en, .pwr_state);
  sdpc_ctl_model ctl_u (.ref_clk, .clk_gate, .cs_n, .ras_n, .cas_n, .we_n, .bank_sel_0, .bank_sel_1,
    .addr, .low_byte_mask, .high_byte_mask, .dq_in);
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // strap changes only under reset
  task automatic do_reset(input logic [1:0] org);
    rst = 1'b1;
    org_sel = org;
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 1'b0;
  endtask
  task automatic wait_pwr(input sdpc_pwr_t st);
    int n = 0;
    while (pwr_state !== st && n < 8) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK("pwr_state", st, pwr_state)
  endtask
  // back-to-back activates to different banks
  task automatic t_act();
    ctl_u.issue(1'b0, C_ACT, 2'h2, 12'hA5C);
    ctl_u.issue(1'b0, C_ACT, 2'h1, 12'hFFF);
    `CHK("cmd_valid", 1'b1, cmd_valid)
    `CHK("cmd_out", SDPC_CMD_ACTIVE, cmd_out)
    `CHK("cmd_bank", 2'h2, cmd_bank)
    `CHK("row_addr", 12'hA5C, row_addr)
    ctl_u.idle();
    `CHK("row_addr", 12'hFFF, row_addr)
    `CHK("cmd_bank", 2'h1, cmd_bank)
  endtask
  // column width per organization, auto precharge flag
  task automatic t_col();
    logic [10:0] exp [3] = '{11'h7FF, 11'h3FF, 11'h1FF};
    for (int o = 0; o < 3; o++) begin
      do_reset(2'(o));
      ctl_u.issue(1'b0, C_RD, 2'h1, 12'hBFF);
      ctl_u.issue(1'b0, C_WR, 2'h3, 12'h400);
      `CHK("col_addr", exp[o], col_addr)
      `CHK("auto_pre", 1'b0, auto_pre)
      ctl_u.idle();
      `CHK("col_addr", 11'h000, col_addr)
      `CHK("auto_pre", 1'b1, auto_pre)
      `CHK("cmd_bank", 2'h3, cmd_bank)
    end
    do_reset(`SDPC_ORG_X16);
  endtask
  task automatic t_pre();
    ctl_u.issue(1'b0, C_PRE, 2'h1, 12'h400);
    ctl_u.issue(1'b0, C_PRE, 2'h3, 12'h000);
    `CHK("pre_banks", 4'hF, pre_banks)
    ctl_u.idle();
    `CHK("pre_banks", 4'h8, pre_banks)
    ctl_u.idle();
    `CHK("pre_banks", 4'h0, pre_banks)
  endtask
  task automatic t_mode();
    ctl_u.issue(1'b0, C_MODE, 2'h0, 12'h237);
    ctl_u.idle();
    `CHK("mode_load", 1'b1, mode_load)
    `CHK("mode_opcode", 12'h237, mode_opcode)
    ctl_u.idle();
    `CHK("mode_load", 1'b0, mode_load)
  endtask
  // deselect in mid-burst: command masked, burst carries on
  task automatic t_cs();
    ctl_u.issue(1'b0, C_ACT, 2'h0, 12'h111);
    ctl_u.issue(1'b0, C_RD, 2'h0, 12'h004);
    ctl_u.issue(1'b1, C_ACT, 2'h0, 12'h777);
    ctl_u.idle();
    `CHK("cmd_valid", 1'b0, cmd_valid)
    `CHK("row_addr", 12'h111, row_addr)
    ctl_u.idle();
    `CHK("rd_active", 1'b1, rd_active)
  endtask
  // burst terminate cuts a read burst short
  task automatic t_term();
    ctl_u.issue(1'b0, C_RD, 2'h2, 12'h030);
    ctl_u.issue(1'b0, C_TERM, 2'h0, 12'h000);
    ctl_u.idle();
    `CHK("cmd_out", SDPC_CMD_BURST_TERM, cmd_out)
    `CHK("rd_active", 1'b1, rd_active)
    ctl_u.idle();
    `CHK("rd_active", 1'b0, rd_active)
  endtask
  // two masked write cycles; enables expected per organization
  task automatic t_wmask(input logic [1:0] org, input logic [15:0] e1, input logic [15:0] e2);
    do_reset(org);
    ctl_u.issue(1'b0, C_WR, 2'h0, 12'h010);
    ctl_u.data(2'b01, 16'h5AA5);
    ctl_u.issue(1'b0, C_WR, 2'h0, 12'h011);
    ctl_u.data(2'b10, 16'h1234);
    `CHK("wr_valid", 1'b1, wr_valid)
    `CHK("wr_data", 16'h5AA5, wr_data)
    `CHK("wr_byte_en", e1, wr_byte_en)
    ctl_u.idle();
    `CHK("wr_byte_en", e2, wr_byte_en)
  endtask
  // mask raised with the read command floats the high byte two edges on
  task automatic t_rmask();
    rd_data = 16'h5A0F;
    ctl_u.issue(1'b0, C_RD, 2'h0, 12'h020);
    ctl_u.data(2'b10, 16'h0000);
    repeat (2) ctl_u.idle();
    `CHK("dq_oe_hi", 8'hFF, dq_oe[15:8])
    ctl_u.idle();
    `CHK("dq_oe_hi", 8'h00, dq_oe[15:8])
    ctl_u.idle();
    `CHK("dq_out", 16'h5A0F, dq_out)
  endtask
  task automatic t_gate();
    ctl_u.gate(1'b0);
    wait_pwr(SDPC_ST_PDOWN);
    `CHK("in_buf_en", 1'b0, in_buf_en)
    `CHK("core_clk_en", 1'b0, core_clk_en)
    ctl_u.issue(1'b0, C_ACT, 2'h1, 12'h0F0);
    ctl_u.idle();
    `CHK("cmd_valid", 1'b0, cmd_valid)
    ctl_u.gate(1'b1);
    wait_pwr(SDPC_ST_RUN);
    ctl_u.issue(1'b0, C_PRE, 2'h0, 12'h400);
    ctl_u.issue(1'b0, C_REF, 2'h0, 12'h000);
    ctl_u.gate(1'b0);
    ctl_u.idle();
    wait_pwr(SDPC_ST_SELF_REF);
    `CHK("in_buf_en", 1'b0, in_buf_en)
    ctl_u.gate(1'b1);
    wait_pwr(SDPC_ST_RUN);
    ctl_u.issue(1'b0, C_RD, 2'h0, 12'h008);
    ctl_u.idle();
    ctl_u.gate(1'b0);
    wait_pwr(SDPC_ST_SUSPEND);
    ctl_u.gate(1'b1);
    wait_pwr(SDPC_ST_RUN);
  endtask
  // main sequence
  initial begin
    do_reset(`SDPC_ORG_X16);
    `CHK("in_buf_en", 1'b1, in_buf_en)
    t_act();
    t_col();
    t_pre();
    t_mode();
    t_cs();
    t_term();
    t_wmask(`SDPC_ORG_X16, 16'hFF00, 16'h00FF);
    t_wmask(`SDPC_ORG_X8, 16'hFFFF, 16'h0000);
    t_rmask();
    t_gate();
    tally_and_finish();
  end
  // watchdog, far beyond the fewer than a hundred cycles the run needs
  initial begin
    #50000;
    fail_count++;
    tally_and_finish();
  end
endmodule // sdram_pin_command_interface_test
